// ---- design/sbcaux_params.svh ----
`ifndef SBCAUX_PARAMS_SVH
`define SBCAUX_PARAMS_SVH
// ==========================================
// Register addresses
`define SBCAUX_ADDR_INIT 6'h03
`define SBCAUX_ADDR_MUX 6'h06
`define SBCAUX_ADDR_REG 6'h0a
// ==========================================
// Command codes and field positions
`define SBCAUX_CMD_READ 2'h0
`define SBCAUX_CMD_WRITE 2'h1
`define SBCAUX_AUX_HI 7
`define SBCAUX_AUX_LO 6
`define SBCAUX_LOWTH_BIT 0
`define SBCAUX_INIT_LVL_BIT 2
`define SBCAUX_INIT_TRK_BIT 1
`define SBCAUX_MUX_SEL_HI 4
`define SBCAUX_MUX_CUR_HI 6
`define SBCAUX_MUX_CUR_LO 5
// ==========================================
// Reset values
`define SBCAUX_REG_RST 8'h00
`define SBCAUX_INIT_RST 8'h00
`define SBCAUX_MUX_RST 8'h08
// ==========================================
// Timing
`define SBCAUX_CLK_NS 8
`define SBCAUX_BLANK_LONG_NS 1000000
`define SBCAUX_BLANK_SHORT_NS 25000
`define SBCAUX_GLITCH_NS 200
`define SBCAUX_BLANK_LONG_CYC \
  ((`SBCAUX_BLANK_LONG_NS + `SBCAUX_CLK_NS - 1) / `SBCAUX_CLK_NS)
`define SBCAUX_BLANK_SHORT_CYC \
  ((`SBCAUX_BLANK_SHORT_NS + `SBCAUX_CLK_NS - 1) / `SBCAUX_CLK_NS)
`define SBCAUX_GLITCH_CYC \
  ((`SBCAUX_GLITCH_NS + `SBCAUX_CLK_NS - 1) / `SBCAUX_CLK_NS)
`define SBCAUX_RAMP_STEP_CYC 16
`endif

// ---- design/sbcaux_pkg.sv ----
package sbcaux_pkg;
  // ==========================================
  // Auxiliary regulator sequencer
  typedef enum logic [1:0] {
    SBCAUX_OFF = 2'b00,
    SBCAUX_RAMP = 2'b01,
    SBCAUX_ON = 2'b10,
    SBCAUX_TRIP = 2'b11
  } sbcaux_st_t;

  // Asynchronous analog and system inputs
  typedef struct packed {
    logic aux_oc;
    logic aux_uv;
    logic aux_ov;
    logic vdd_uv;
    logic vdd_low;
    logic wd_fail;
    logic batt_uv;
    logic main_5v;
    logic [5:0] sw;
  } sbcaux_in_t;

  typedef struct packed {
    sbcaux_in_t a1;
    sbcaux_in_t a2;
    logic [2:0] p1;
    logic [2:0] p2;
    logic sclk_d;
    logic cs_d;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [4:0] bits;
    logic any_bit;
    logic [7:0] csl;
    logic miso;
    logic miso_oe;
    logic [1:0][31:0] buf_mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [7:0] reg_ctrl;
    logic [7:0] reg_init;
    logic [7:0] reg_mux;
    logic rd_pend;
    logic [5:0] rd_addr;
    sbcaux_st_t aux;
    logic [16:0] blank;
    logic [3:0] ramp;
    logic [3:0] rstep;
    logic f_oc;
    logic f_uv;
    logic f_ov;
    logic f_low;
    logic overrun;
    logic aux_en;
    logic protect_on;
    logic irq;
    logic trk;
    logic rst_oe;
    logic sleep_uv;
  } sbcaux_state_t;
endpackage : sbcaux_pkg

// ---- design/sbcaux_spi_supply.sv ----
`timescale 1ns/1ns
`include "sbcaux_params.svh"
module sbcaux_spi_supply #(
  parameter int BLANK_LONG = `SBCAUX_BLANK_LONG_CYC,
  parameter int BLANK_SHORT = `SBCAUX_BLANK_SHORT_CYC,
  parameter int GLITCH = `SBCAUX_GLITCH_CYC,
  parameter int RAMP_STEP = `SBCAUX_RAMP_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic init_state,
  input wire logic normal_mode,
  input wire logic sleep_mode,
  input wire logic scan_tick,
  input wire logic word_hold,
  input wire logic aux_oc,
  input wire logic aux_uv,
  input wire logic aux_ov,
  input wire logic vdd_uv,
  input wire logic vdd_low,
  input wire logic wd_fail,
  input wire logic batt_uv,
  input wire logic main_5v,
  input wire logic [5:0] switch_inputs,
  output logic aux_regulator_en,
  output logic [3:0] aux_ramp_level,
  output logic aux_level_5v,
  output logic aux_tracking,
  output logic aux_protect_on,
  output logic [4:0] monitor_select,
  output logic [1:0] switch_current,
  output logic int_req,
  output logic rst_oe,
  output logic wake_req
);
  sbcaux_pkg::sbcaux_state_t q, d;
  sbcaux_pkg::sbcaux_in_t ain;
  logic sclk_rise, cs_fall, cs_rise, cs_act, pop, push;
  logic [1:0] code;
  logic fault, reported, trk_ok, blocked;
  logic [16:0] blank_lim;
  logic [5:0] sw_rep;
  logic [31:0] stat, w;

  assign ain = '{aux_oc, aux_uv, aux_ov, vdd_uv, vdd_low, wd_fail, batt_uv,
    main_5v, switch_inputs};

  always_comb begin
    d = q;
    // ==========================================
    // Synchronisers
    d.a1 = ain;
    d.a2 = q.a1;
    d.p1 = {sclk, cs_n, mosi};
    d.p2 = q.p1;
    d.sclk_d = q.p2[2];
    d.cs_d = q.p2[1];
    cs_act = !q.p2[1];
    sclk_rise = q.p2[2] && !q.sclk_d && cs_act;
    cs_fall = !q.p2[1] && q.cs_d;
    cs_rise = q.p2[1] && !q.cs_d;

    // ==========================================
    // Status word
    code = q.reg_ctrl[`SBCAUX_AUX_HI:`SBCAUX_AUX_LO];
    reported = code[1];
    sw_rep = q.a2.sw;
    for (int i = 0; i < 6; i++) begin
      if (q.reg_mux[`SBCAUX_MUX_SEL_HI:0] == 5'(i + 1)) begin
        sw_rep[i] = 1'b0;
      end
    end
    stat = {q.f_oc, q.f_uv, q.f_ov, q.f_low, q.a2.wd_fail, q.aux_en,
      q.aux == sbcaux_pkg::SBCAUX_TRIP, q.overrun, 4'h0, 14'h0000, sw_rep};
    if (q.rd_pend) begin
      if (q.rd_addr == `SBCAUX_ADDR_REG) begin
        stat[23:0] = {16'h0000, q.reg_ctrl};
      end else if (q.rd_addr == `SBCAUX_ADDR_INIT) begin
        stat[23:0] = {16'h0000, q.reg_init};
      end else if (q.rd_addr == `SBCAUX_ADDR_MUX) begin
        stat[23:0] = {16'h0000, q.reg_mux};
      end else begin
        stat[23:0] = 24'h000000;
      end
    end

    // ==========================================
    // Serial shifter
    if (cs_fall) begin
      d.miso_oe = 1'b1;
      d.tx = stat;
      d.miso = stat[31];
      d.bits = 5'h00;
      d.any_bit = 1'b0;
      d.csl = 8'h00;
    end else if (cs_act) begin
      if (q.csl != 8'hff) begin
        d.csl = q.csl + 8'h01;
      end
      if (sclk_rise) begin
        d.rx = {q.rx[30:0], q.p2[0]};
        d.tx = {q.tx[30:0], 1'b0};
        d.miso = q.tx[30];
        d.bits = q.bits + 5'h01;
        d.any_bit = 1'b1;
      end
    end
    if (cs_rise) begin
      d.miso_oe = 1'b0;
      d.miso = 1'b0;
    end

    // ==========================================
    // Frame acceptance into two-entry buffer
    push = cs_rise && 32'(q.csl) >= GLITCH && q.bits == 5'h00 && q.any_bit;
    pop = q.cnt != 2'h0 && !word_hold;
    w = q.buf_mem[q.rp];
    // Reload first so a same-edge drop still shows
    if (cs_rise && 32'(q.csl) >= GLITCH) begin
      d.overrun = 1'b0;
    end
    if (push) begin
      if (q.cnt == 2'h2 && !pop) begin
        d.overrun = 1'b1;
      end else begin
        d.buf_mem[q.wp] = q.rx;
        d.wp = !q.wp;
      end
    end
    if (pop) begin
      d.rp = !q.rp;
    end
    d.cnt = q.cnt + {1'b0, push && (q.cnt != 2'h2 || pop)} - {1'b0, pop};

    // ==========================================
    // Register reads and writes
    if (pop && w[31:30] == `SBCAUX_CMD_READ) begin
      d.rd_pend = 1'b1;
      d.rd_addr = w[29:24];
    end else if (pop) begin
      d.rd_pend = 1'b0;
    end
    if (pop && w[31:30] == `SBCAUX_CMD_WRITE) begin
      if (w[29:24] == `SBCAUX_ADDR_REG) begin
        d.reg_ctrl = w[7:0];
        d.aux = sbcaux_pkg::SBCAUX_OFF;
      end else if (w[29:24] == `SBCAUX_ADDR_INIT && init_state) begin
        d.reg_init = w[7:0];
      end else if (w[29:24] == `SBCAUX_ADDR_MUX) begin
        d.reg_mux = w[7:0];
      end
    end

    // ==========================================
    // Aux regulator sequencer
    trk_ok = q.a2.main_5v && q.reg_init[`SBCAUX_INIT_LVL_BIT];
    d.trk = q.reg_init[`SBCAUX_INIT_TRK_BIT] && trk_ok;
    blocked = q.reg_init[`SBCAUX_INIT_TRK_BIT] && !q.a2.main_5v;
    fault = q.a2.aux_oc || (q.a2.aux_uv && q.aux == sbcaux_pkg::SBCAUX_ON);
    blank_lim = (code == 2'h3) ? 17'(BLANK_SHORT) : 17'(BLANK_LONG);
    case (q.aux)
      sbcaux_pkg::SBCAUX_OFF: begin
        d.blank = 17'h00000;
        d.ramp = 4'h0;
        d.rstep = 4'h0;
        if (code != 2'h0 && !blocked) begin
          d.aux = sbcaux_pkg::SBCAUX_RAMP;
        end
      end
      sbcaux_pkg::SBCAUX_RAMP: begin
        d.rstep = q.rstep + 4'h1;
        if (32'(q.rstep) == RAMP_STEP - 1) begin
          d.rstep = 4'h0;
          d.ramp = q.ramp + 4'h1;
          if (q.ramp == 4'he) begin
            d.aux = sbcaux_pkg::SBCAUX_ON;
          end
        end
      end
      sbcaux_pkg::SBCAUX_ON: begin
        d.aux = sbcaux_pkg::SBCAUX_ON;
      end
      default: begin
        d.aux = sbcaux_pkg::SBCAUX_TRIP;
      end
    endcase
    if (q.aux == sbcaux_pkg::SBCAUX_RAMP || q.aux == sbcaux_pkg::SBCAUX_ON) begin
      if (!fault) begin
        d.blank = 17'h00000;
      end else if (q.blank >= blank_lim - 17'h00001) begin
        d.aux = sbcaux_pkg::SBCAUX_TRIP;
      end else begin
        d.blank = q.blank + 17'h00001;
      end
      if (code == 2'h0 || blocked) begin
        d.aux = sbcaux_pkg::SBCAUX_OFF;
      end
    end
    if (pop && w[31:30] == `SBCAUX_CMD_WRITE && w[29:24] == `SBCAUX_ADDR_REG) begin
      d.aux = sbcaux_pkg::SBCAUX_OFF;
    end
    d.aux_en = d.aux == sbcaux_pkg::SBCAUX_RAMP || d.aux == sbcaux_pkg::SBCAUX_ON;
    d.protect_on = !q.a2.aux_ov;

    // ==========================================
    // Fault flags, set wins over reload
    if (cs_rise && 32'(q.csl) >= GLITCH) begin
      d.f_oc = 1'b0;
      d.f_uv = 1'b0;
      d.f_ov = 1'b0;
      d.f_low = 1'b0;
    end
    if (reported && q.a2.aux_oc && q.aux_en) begin
      d.f_oc = 1'b1;
    end
    if (reported && q.a2.aux_uv && q.aux == sbcaux_pkg::SBCAUX_ON) begin
      d.f_uv = 1'b1;
    end
    if (reported && q.a2.aux_ov && q.aux_en) begin
      d.f_ov = 1'b1;
    end
    if (q.reg_ctrl[`SBCAUX_LOWTH_BIT] && normal_mode && q.a2.vdd_low) begin
      d.f_low = 1'b1;
    end
    d.irq = d.f_oc || d.f_uv || d.f_ov || d.f_low;

    // ==========================================
    // Reset and wake
    if (sleep_mode && scan_tick && q.a2.batt_uv) begin
      d.sleep_uv = 1'b1;
    end else if (!sleep_mode && !q.a2.batt_uv) begin
      d.sleep_uv = 1'b0;
    end
    d.rst_oe = (q.a2.vdd_uv && !(q.reg_ctrl[`SBCAUX_LOWTH_BIT] && normal_mode))
      || q.a2.wd_fail || d.sleep_uv;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.p1 <= 3'h2;
      q.p2 <= 3'h2;
      q.cs_d <= 1'b1;
      q.reg_ctrl <= `SBCAUX_REG_RST;
      q.reg_init <= `SBCAUX_INIT_RST;
      q.reg_mux <= `SBCAUX_MUX_RST;
      q.aux <= sbcaux_pkg::SBCAUX_OFF;
      q.protect_on <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs
  assign miso = q.miso;
  assign miso_oe = q.miso_oe;
  assign aux_regulator_en = q.aux_en;
  assign aux_ramp_level = q.ramp;
  assign aux_level_5v = q.reg_init[`SBCAUX_INIT_LVL_BIT];
  assign aux_tracking = q.trk;
  assign aux_protect_on = q.protect_on;
  assign monitor_select = q.reg_mux[`SBCAUX_MUX_SEL_HI:0];
  assign switch_current = q.reg_mux[`SBCAUX_MUX_CUR_HI:`SBCAUX_MUX_CUR_LO];
  assign int_req = q.irq;
  assign rst_oe = q.rst_oe;
  assign wake_req = q.sleep_uv;
endmodule : sbcaux_spi_supply

// ---- tb/sbcaux_host_model.sv ----
`timescale 1ns/1ns
module sbcaux_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ========
  // Master frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    cs_n = 1'b0;
    mosi = w[31];
    #40;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      r = {r[30:0], miso_oe ? miso : ~miso};
      #40;
      sclk = 1'b0;
      w = w << 1;
      mosi = w[31];
      #40;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask : xfer
endmodule : sbcaux_host_model

// ---- tb/sbcaux_spi_supply_sva.sv ----
`timescale 1ns/1ns
module sbcaux_spi_supply_sva #(
  parameter int BLANK_LONG = 125000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic init_state,
  input wire logic aux_oc,
  input wire logic aux_ov,
  input wire logic wd_fail,
  input wire logic main_5v,
  input wire logic aux_regulator_en,
  input wire logic [3:0] aux_ramp_level,
  input wire logic aux_level_5v,
  input wire logic aux_tracking,
  input wire logic aux_protect_on,
  input wire logic [4:0] monitor_select,
  input wire logic rst_oe
);
  // ========
  // Fault duration counter
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [17:0] oc_q;
  logic [17:0] oc_d;
  always_comb oc_d = (aux_oc && aux_regulator_en) ? oc_q + 18'h1 : 18'h0;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) oc_q <= 18'h0;
    else oc_q <= oc_d;
  end
  sequence s_sel_low;
    !cs_n [*6];
  endsequence
  sequence s_sel_high;
    cs_n [*6];
  endsequence
  property p_oe_on;
    s_sel_low |-> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso not driven");
  property p_oe_off;
    s_sel_high |-> !miso_oe && !miso;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso not released");
  property p_ramp;
    $rose(aux_regulator_en) |-> aux_ramp_level == 4'h0;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not from zero");
  property p_track;
    aux_tracking |-> aux_level_5v && $past(main_5v, 3);
  endproperty
  a_track: assert property (p_track) else $error("bad tracking");
  property p_prot_off;
    aux_ov [*4] |-> !aux_protect_on;
  endproperty
  a_prot_off: assert property (p_prot_off) else $error("switch closed");
  property p_prot_on;
    !aux_ov [*4] |-> aux_protect_on;
  endproperty
  a_prot_on: assert property (p_prot_on) else $error("switch open");
  property p_lock;
    $changed(aux_level_5v) |-> $past(init_state);
  endproperty
  a_lock: assert property (p_lock) else $error("init written late");
  property p_rst_wd;
    wd_fail [*4] |-> rst_oe;
  endproperty
  a_rst_wd: assert property (p_rst_wd) else $error("no reset");
  property p_dflt;
    $past(reset) |-> monitor_select == 5'h08 && !aux_regulator_en;
  endproperty
  a_dflt: assert property (p_dflt) else $error("bad reset state");
  property p_trip;
    oc_q < 18'(BLANK_LONG + 8);
  endproperty
  a_trip: assert property (p_trip) else $error("no fault shutdown");
endmodule : sbcaux_spi_supply_sva
bind sbcaux_spi_supply sbcaux_spi_supply_sva #(.BLANK_LONG(BLANK_LONG))
  sbcaux_spi_supply_sva_i (.clock, .reset, .cs_n, .miso, .miso_oe, .init_state, .aux_oc,
  .aux_ov, .wd_fail, .main_5v, .aux_regulator_en, .aux_ramp_level, .aux_level_5v,
  .aux_tracking, .aux_protect_on, .monitor_select, .rst_oe);

// ---- tb/sbcaux_spi_supply_tb_top.sv ----
`timescale 1ns/1ns
module sbcaux_spi_supply_tb_top;
  localparam int BL = 200;
  localparam int BS = 50;
  localparam int RS = 2;
  logic clock, reset, sclk, cs_n, mosi, miso, miso_oe, init_state, normal_mode;
  logic sleep_mode, scan_tick, word_hold, aux_oc, aux_uv, aux_ov, vdd_uv, vdd_low;
  logic wd_fail, batt_uv, main_5v, aux_regulator_en, aux_level_5v, aux_tracking;
  logic aux_protect_on, int_req, rst_oe, wake_req;
  logic [5:0] switch_inputs;
  logic [3:0] aux_ramp_level;
  logic [4:0] monitor_select;
  logic [1:0] switch_current;
  logic [31:0] r, seed;
  logic [7:0] mv;
  int bad_count, n_checks, bl;
  sbcaux_spi_supply #(.BLANK_LONG(BL), .BLANK_SHORT(BS), .GLITCH(25), .RAMP_STEP(RS))
    sbcaux_spi_supply_i (.clock, .reset, .sclk, .cs_n, .mosi, .miso, .miso_oe, .init_state,
    .normal_mode, .sleep_mode, .scan_tick, .word_hold, .aux_oc, .aux_uv, .aux_ov, .vdd_uv,
    .vdd_low, .wd_fail, .batt_uv, .main_5v, .switch_inputs, .aux_regulator_en,
    .aux_ramp_level, .aux_level_5v, .aux_tracking, .aux_protect_on, .monitor_select,
    .switch_current, .int_req, .rst_oe, .wake_req);
  sbcaux_host_model sbcaux_host_model_i (.sclk, .cs_n, .mosi, .miso, .miso_oe);
  // ========
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nxt
  function automatic logic [5:0] sw_exp(input logic [5:0] sw, input logic [4:0] sel);
    return (sel >= 5'd1 && sel <= 5'd6) ? sw & ~(6'h01 << (sel - 5'd1)) : sw;
  endfunction : sw_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    sbcaux_host_model_i.xfer({2'b01, a, 16'h0000, d}, 32, r);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    sbcaux_host_model_i.xfer({2'b00, a, 24'h000000}, 32, r);
    sbcaux_host_model_i.xfer({2'b00, a, 24'h000000}, 32, r);
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #600000;
    bad_count++;
    end_of_test();
  end
  // ========
  // Scenarios
  initial begin
    {reset, init_state, main_5v} = 3'b111;
    {normal_mode, sleep_mode, scan_tick, word_hold, aux_oc, aux_uv, aux_ov} = 7'h00;
    {vdd_uv, vdd_low, wd_fail, batt_uv} = 4'h0;
    switch_inputs = 6'h3f;
    seed = 32'h05d7;
    bad_count = 0;
    n_checks = 0;
    repeat (20) @(posedge clock);
    #1 reset = 1'b0;
    cyc(2);
    chk({monitor_select, aux_regulator_en, aux_protect_on}, 7'h21);
    wr(6'h03, 8'h06);
    chk({aux_level_5v, aux_tracking}, 2'b11);
    {init_state, normal_mode} = 2'b01;
    wr(6'h03, 8'h00);
    chk(aux_level_5v, 1'b1);
    for (int i = 0; i < 10; i++) begin
      seed = nxt(seed);
      switch_inputs = seed[13:8];
      mv = {1'b0, seed[6:5], 5'((i + 1) % 10)};
      wr(6'h06, mv);
      wr(6'h06, mv);
      chk({switch_current, monitor_select}, mv[6:0]);
      chk(r[5:0], sw_exp(switch_inputs, mv[4:0]));
    end
    wr(6'h3f, 8'h55);
    sbcaux_host_model_i.xfer({2'b01, 6'h06, 24'h000003}, 31, r);
    rd(6'h06);
    chk(r[23:0], {16'h0000, mv});
    word_hold = 1'b1;
    for (int k = 1; k < 4; k++) wr(6'h06, 8'(k));
    chk(monitor_select, 5'h00);
    word_hold = 1'b0;
    cyc(6);
    chk(monitor_select, 5'h02);
    wr(6'h06, 8'h08);
    chk(r[24], 1'b1);
    for (int c = 1; c < 4; c++) begin
      wr(6'h0a, {c[1:0], 6'h00});
      cyc(16 * RS + 8);
      chk({aux_regulator_en, aux_ramp_level}, 5'h1f);
      bl = (c == 3) ? BS : BL;
      aux_oc = 1'b1;
      cyc(bl - 10);
      aux_oc = 1'b0;
      cyc(3);
      aux_oc = 1'b1;
      cyc(bl - 4);
      chk(aux_regulator_en, 1'b1);
      cyc(12);
      chk({aux_regulator_en, int_req}, {1'b0, c != 1});
      aux_oc = 1'b0;
      cyc(10);
      chk(aux_regulator_en, 1'b0);
    end
    wr(6'h0a, 8'h80);
    cyc(40);
    aux_uv = 1'b1;
    cyc(BL + 12);
    chk({aux_regulator_en, int_req}, 2'b01);
    aux_uv = 1'b0;
    wr(6'h3f, 8'h00);
    chk(r[31:24], 8'h42);
    vdd_uv = 1'b1;
    cyc(6);
    chk(rst_oe, 1'b1);
    vdd_uv = 1'b0;
    wd_fail = 1'b1;
    cyc(6);
    chk(rst_oe, 1'b1);
    wd_fail = 1'b0;
    wr(6'h0a, 8'hc0);
    wr(6'h0a, 8'h01);
    chk(aux_regulator_en, 1'b0);
    vdd_low = 1'b1;
    cyc(6);
    chk({rst_oe, int_req}, 2'b01);
    {vdd_low, aux_ov} = 2'b01;
    cyc(6);
    chk(aux_protect_on, 1'b0);
    {aux_ov, main_5v} = 2'b00;
    cyc(6);
    chk(aux_protect_on, 1'b1);
    sbcaux_host_model_i.xfer(32'h0, 0, r);
    chk(int_req, 1'b1);
    wr(6'h0a, 8'h80);
    cyc(40);
    chk(aux_regulator_en, 1'b0);
    chk(int_req, 1'b0);
    {main_5v, normal_mode, sleep_mode, batt_uv} = 4'hb;
    cyc(3);
    scan_tick = 1'b1;
    cyc(1);
    scan_tick = 1'b0;
    cyc(4);
    chk({wake_req, rst_oe}, 2'b11);
    end_of_test();
  end
endmodule : sbcaux_spi_supply_tb_top
